// ===== rtl/spfp_pkg.sv
// Shared constants and types of the supply-pulse fuse programmer.
// Assumes a 200 MHz core clock and two supply-level comparators outside.
package spfp_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    // Glitch filter: a level must hold this long before it is believed
    localparam int GLITCH_NS = 2000;
    localparam int GLITCH_CYC = (GLITCH_NS * 1000) / CLK_PERIOD_PS;
    localparam int FILT_W = 10;
    // ----------------------------------------
    // Supply level codes
    // ----------------------------------------
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    // ----------------------------------------
    // Register keys, codes and fields
    // ----------------------------------------
    localparam int FIELD_W = 6;
    localparam logic [3:0] KEY_TRIM_UP = 4'h0;
    localparam logic [3:0] KEY_TRIM_DOWN = 4'h1;
    localparam logic [3:0] KEY_FUSE_CHECK = 4'h7;
    localparam logic [3:0] KEY_BLOW_MODE = 4'h9;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [5:0] CODE_PRESET = 6'h01;
    localparam logic [5:0] CODE_MAX = 6'h3F;
    localparam logic [5:0] CODE_CHECK_LOW = 6'h07;
    localparam logic [5:0] CODE_CHECK_HIGH = 6'h0F;
    localparam logic [5:0] FIELD_LOCK = 6'h08;
    localparam logic [5:0] FIELD_INIT = 6'h00;
    localparam logic [5:0] FIELD_FIRST = 6'h01;
    // ----------------------------------------
    // Fuse bank: six trim fuses and one lock fuse
    // ----------------------------------------
    typedef struct packed {
        logic [5:0] trim;
        logic lock;
    } spfp_fuse_t;
    localparam spfp_fuse_t FUSE_NONE = '{trim: 6'h00, lock: 1'b0};
endpackage

// ===== rtl/spfp_programmer.sv
// Supply-pulse decoder and fuse programmer of a two-wire magnetic switch.
// Assumes two comparators report the supply against the mid and high
// program levels, a fuse bank reports burned fuses and takes burn strobes,
// and that supply power-up drives nrst.
//
// Overview of operation
// R1 - Field code is the binary fuse pattern, bit 0 weighing one.
// R2 - Addressed values act on the trim now, permanent only when burned.
// R3 - A burned fuse reads set forever; nothing clears it.
// R4 - Programmer selects a register: high, some mid pulses, high.
// R5 - Mid pulses between the two selection highs form the register key.
// R6 - Key zero is sent as no mid pulse between the two highs.
// R7 - After selection the device is in Try mode unless Blow key follows.
// R8 - Blow key is nine mid pulses then one high pulse.
// R9 - Try key 0: up-counting trim, code equals field, 63 gives 111111.
// R10 - Try key 1: down-counting trim, field is inverse of code.
// R11 - Try key 7: code 7 checks low threshold, code 15 high threshold.
// R12 - Blow key 0 addresses trim field, one bit per sequence.
// R13 - Blow key 7 code 8 burns lock; lock denies all but fuse check.
// R14 - Try mode adds one to the field at each mid pulse fall.
// R15 - Try counting stops at the field maximum without wrapping.
// R16 - Power cycle drops Try settings; only burned bits remain.
// R17 - Trim code is preset to 1 when the final selection high falls.
// R18 - Programmer burns: selection, Blow key, address pulses, burn pulse.
// R19 - At most one fuse burns per burn pulse; field is one-hot.
// R20 - Blow mode: n mid pulses give one-hot bit n minus one.
// R21 - Blow field starts at zero before any mid pulse.
// R22 - Programmer drives low, mid and high supply levels.
// R23 - Burn pulse stays high for at least 90 us.
// R24 - Key and code pulses and gaps last at least 20 us.
// R25 - Supply level is synchronised, glitch filtered, counted on return.
// R26 - After power-up wait idle for a high pulse; mids ignored.
`timescale 1ns/10ps
`default_nettype none
module spfp_programmer #(
    parameter int GLITCH_CYCLES = spfp_pkg::GLITCH_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic mid_program_level,
    input wire logic high_program_level,
    input wire spfp_pkg::spfp_fuse_t fuse_sense,
    output var spfp_pkg::spfp_fuse_t fuse_burn,
    output logic [5:0] operate_threshold,
    output logic check_low,
    output logic check_high,
    output logic blow_mode,
    output logic seq_done
);
    // ----------------------------------------
    // Level synchroniser and glitch filter
    // ----------------------------------------
    logic [1:0] sync1_r, sync2_r, sync3_r;
    logic [1:0] cand_r, cand_nxt;
    logic [1:0] lvl_r, lvl_nxt;
    logic [1:0] peak_r, peak_nxt;
    logic [9:0] filt_r, filt_nxt;
    logic pulse_end, high_start;
    logic [1:0] raw_lvl;

    function automatic logic [1:0] lvl_code(input logic [1:0] cmp);
        // High comparator wins: mid is also above its threshold then
        if (cmp[1])
            return spfp_pkg::LVL_HIGH;
        else if (cmp[0])
            return spfp_pkg::LVL_MID;
        return spfp_pkg::LVL_LOW;
    endfunction

    // A level counts only while the second and third stages agree
    always_comb
    begin
        raw_lvl = lvl_code(sync3_r);
        cand_nxt = cand_r;
        filt_nxt = filt_r;
        lvl_nxt = lvl_r;
        if (sync2_r != sync3_r || raw_lvl != cand_r)
        begin
            cand_nxt = (sync2_r == sync3_r) ? raw_lvl : cand_r;
            filt_nxt = '0;
        end
        else if (filt_r < 10'(GLITCH_CYCLES - 1))
            filt_nxt = filt_r + 10'h001;
        else
            lvl_nxt = cand_r; // see R25
        // Peak seen during the pulse decides its kind
        peak_nxt = peak_r;
        if (lvl_r == spfp_pkg::LVL_LOW)
            peak_nxt = lvl_nxt;
        else if (lvl_nxt == spfp_pkg::LVL_HIGH)
            peak_nxt = spfp_pkg::LVL_HIGH;
    end

    // Pulse ends only on return to low, so a rising edge through mid
    // on the way to high is never taken as a mid pulse
    assign pulse_end = (lvl_r != spfp_pkg::LVL_LOW) &&
        (lvl_nxt == spfp_pkg::LVL_LOW); // see R25
    assign high_start = (lvl_r != spfp_pkg::LVL_HIGH) &&
        (lvl_nxt == spfp_pkg::LVL_HIGH);

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
            sync3_r <= 2'h0;
            cand_r <= spfp_pkg::LVL_LOW;
            lvl_r <= spfp_pkg::LVL_LOW;
            peak_r <= spfp_pkg::LVL_LOW;
            filt_r <= 10'h000;
        end
        else
        begin
            sync1_r <= {high_program_level, mid_program_level};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            cand_r <= cand_nxt;
            lvl_r <= lvl_nxt;
            peak_r <= peak_nxt;
            filt_r <= filt_nxt;
        end
    end

    // ----------------------------------------
    // Programming sequencer
    // ----------------------------------------
    typedef enum logic [5:0] {
        SP_IDLE = 6'b000001,
        SP_KEY = 6'b000010,
        SP_TRY = 6'b000100,
        SP_BLOW = 6'b001000,
        SP_BURN = 6'b010000,
        SP_DONE = 6'b100000
    } spfp_state_t;

    spfp_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [3:0] key_r, key_nxt;
    logic [5:0] code_r, code_nxt;
    logic [5:0] field_r, field_nxt;
    spfp_pkg::spfp_fuse_t burn_r, burn_nxt;
    logic [5:0] trim_r, trim_nxt;
    logic chk_lo_r, chk_lo_nxt, chk_hi_r, chk_hi_nxt;
    logic pm, ph;
    logic blow_r, blow_nxt, done_r, done_nxt;

    always_comb
    begin
        pm = pulse_end && peak_r == spfp_pkg::LVL_MID;
        ph = pulse_end && peak_r == spfp_pkg::LVL_HIGH;
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        key_nxt = key_r;
        code_nxt = code_r;
        field_nxt = field_r;
        burn_nxt = spfp_pkg::FUSE_NONE;
        case (state_r)
            // Mid pulses before the first high are ignored
            SP_IDLE:
                if (ph) // see R26
                begin
                    state_nxt = SP_KEY;
                    cnt_nxt = 4'h0;
                end
            SP_KEY:
                if (pm && cnt_r != spfp_pkg::CNT_MAX)
                    cnt_nxt = cnt_r + 4'h1; // see R5, R6
                else if (ph)
                begin
                    key_nxt = cnt_r; // see R5, R6
                    cnt_nxt = 4'h0;
                    // Lock leaves only the fuse check open
                    if (fuse_sense.lock && cnt_r != spfp_pkg::KEY_FUSE_CHECK)
                        state_nxt = SP_DONE; // see R13
                    else
                        state_nxt = SP_TRY; // see R7
                    // Trim keys start counting at code 1
                    if (cnt_r == spfp_pkg::KEY_TRIM_UP ||
                        cnt_r == spfp_pkg::KEY_TRIM_DOWN)
                        code_nxt = spfp_pkg::CODE_PRESET; // see R17
                    else
                        code_nxt = '0;
                end
            SP_TRY:
                if (pm)
                begin
                    if (cnt_r != spfp_pkg::CNT_MAX)
                        cnt_nxt = cnt_r + 4'h1;
                    if (code_r != spfp_pkg::CODE_MAX)
                        code_nxt = code_r + 6'h01; // see R14, R15
                end
                else if (ph)
                begin
                    // Nine mids then high switch to Blow; Try value is dropped
                    if (cnt_r == spfp_pkg::KEY_BLOW_MODE)
                    begin
                        state_nxt = SP_BLOW; // see R8
                        field_nxt = spfp_pkg::FIELD_INIT; // see R21
                        code_nxt = '0;
                    end
                    else
                        state_nxt = SP_DONE;
                end
            SP_BLOW:
                if (pm)
                    // One-hot shift; a seventh pulse shifts the bit out
                    field_nxt = (field_r == spfp_pkg::FIELD_INIT) ?
                        spfp_pkg::FIELD_FIRST : {field_r[4:0], 1'b0}; // see R20
                else if (high_start)
                    state_nxt = SP_BURN; // see R19
            SP_BURN:
            begin
                // Strobe held only while the supply stays high
                if (lvl_r == spfp_pkg::LVL_HIGH)
                begin
                    if (key_r == spfp_pkg::KEY_TRIM_UP)
                        burn_nxt.trim = field_r; // see R12, R19
                    else if (key_r == spfp_pkg::KEY_FUSE_CHECK &&
                        field_r == spfp_pkg::FIELD_LOCK)
                        burn_nxt.lock = 1'b1; // see R13
                end
                if (pulse_end)
                begin
                    state_nxt = SP_DONE;
                    burn_nxt = spfp_pkg::FUSE_NONE;
                end
            end
            // Only a power cycle starts a new sequence
            SP_DONE:
                state_nxt = SP_DONE;
            default:
                state_nxt = SP_IDLE;
        endcase
        // Try value sits on top of burned fuses, which always read set
        trim_nxt = fuse_sense.trim; // see R2, R3, R16
        if (state_r == SP_TRY && key_r == spfp_pkg::KEY_TRIM_UP)
            trim_nxt = fuse_sense.trim | code_r; // see R1, R9
        else if (state_r == SP_TRY && key_r == spfp_pkg::KEY_TRIM_DOWN)
            trim_nxt = fuse_sense.trim | ~code_r; // see R10
        chk_lo_nxt = state_r == SP_TRY && key_r == spfp_pkg::KEY_FUSE_CHECK &&
            code_r == spfp_pkg::CODE_CHECK_LOW; // see R11
        chk_hi_nxt = state_r == SP_TRY && key_r == spfp_pkg::KEY_FUSE_CHECK &&
            code_r == spfp_pkg::CODE_CHECK_HIGH; // see R11
        blow_nxt = state_nxt == SP_BLOW || state_nxt == SP_BURN;
        done_nxt = state_nxt == SP_DONE; // see R13
    end

    // Synchronous reset stands in for supply power-up
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            state_r <= SP_IDLE; // see R16
            cnt_r <= 4'h0;
            key_r <= 4'h0;
            code_r <= 6'h00;
            field_r <= spfp_pkg::FIELD_INIT;
            burn_r <= spfp_pkg::FUSE_NONE;
            trim_r <= 6'h00;
            chk_lo_r <= 1'b0;
            chk_hi_r <= 1'b0;
            blow_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            key_r <= key_nxt;
            code_r <= code_nxt;
            field_r <= field_nxt;
            burn_r <= burn_nxt;
            trim_r <= trim_nxt;
            chk_lo_r <= chk_lo_nxt;
            chk_hi_r <= chk_hi_nxt;
            blow_r <= blow_nxt;
            done_r <= done_nxt;
        end
    end

    assign fuse_burn = burn_r;
    assign operate_threshold = trim_r;
    assign check_low = chk_lo_r;
    assign check_high = chk_hi_r;
    assign blow_mode = blow_r;
    assign seq_done = done_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_burn_one_hot: assert property (@(posedge core_clk) // see R19
        disable iff (!nrst) $onehot0({burn_r.trim, burn_r.lock}))
        else $error("more than one fuse strobed");
    a_burned_reads_set: assert property (@(posedge core_clk) // see R3
        disable iff (!nrst)
        $past(nrst) |-> (($past(fuse_sense.trim) & ~trim_r) == 6'h00))
        else $error("burned trim bit not applied");
    a_try_no_wrap: assert property (@(posedge core_clk) // see R15
        disable iff (!nrst)
        (state_r == SP_TRY && code_r == spfp_pkg::CODE_MAX && pm) |=>
        code_r == spfp_pkg::CODE_MAX)
        else $error("try code wrapped");
    a_try_step: assert property (@(posedge core_clk) // see R14
        disable iff (!nrst)
        (state_r == SP_TRY && code_r != spfp_pkg::CODE_MAX && pm) |=>
        code_r == $past(code_r) + 6'h01)
        else $error("try code not stepped");
    a_preset_one: assert property (@(posedge core_clk) // see R17
        disable iff (!nrst)
        (state_r == SP_KEY && ph && cnt_r <= spfp_pkg::KEY_TRIM_DOWN &&
        !fuse_sense.lock) |=> state_r == SP_TRY && code_r == 6'h01)
        else $error("trim code not preset");
    a_lock_denies: assert property (@(posedge core_clk) // see R13
        disable iff (!nrst)
        (state_r == SP_KEY && ph && fuse_sense.lock &&
        cnt_r != spfp_pkg::KEY_FUSE_CHECK) |=> ##[0:2] seq_done)
        else $error("locked device accepted register");
    a_blow_start_zero: assert property (@(posedge core_clk) // see R21
        disable iff (!nrst)
        (state_r == SP_TRY && ph && cnt_r == spfp_pkg::KEY_BLOW_MODE) |=>
        state_r == SP_BLOW && field_r == 6'h00)
        else $error("blow field not cleared");
    a_blow_shift: assert property (@(posedge core_clk) // see R20
        disable iff (!nrst)
        (state_r == SP_BLOW && pm && field_r == 6'h00) |=> field_r == 6'h01)
        else $error("first blow pulse not bit 0");
    a_idle_ignores_mid: assert property (@(posedge core_clk) // see R26
        disable iff (!nrst)
        (state_r == SP_IDLE && !ph) |=> state_r == SP_IDLE)
        else $error("idle left without high pulse");
    a_down_inverse: assert property (@(posedge core_clk) // see R10
        disable iff (!nrst)
        (state_r == SP_TRY && key_r == spfp_pkg::KEY_TRIM_DOWN &&
        $stable(state_r)) |=> trim_r == (fuse_sense.trim | ~$past(code_r)))
        else $error("down trim not inverted");
endmodule
`default_nettype wire

// ===== verification/spfp_prog_model.sv
// End-of-line programmer model: drives the two supply comparators.
// Assumes the bench calls its tasks; levels change on falling clock edges.
`timescale 1ns/10ps
`default_nettype none
module spfp_prog_model (
    input wire logic core_clk,
    output logic mid_program_level,
    output logic high_program_level
);
    // ----------------------------------------
    // Pulse widths in clock cycles
    // ----------------------------------------
    localparam int T_ACT = 20;
    localparam int T_LOW = 20;
    localparam int T_BURN = 90; // Burn minimum on the same scale

    // Supply rests at the low level outside pulses
    initial
    begin
        mid_program_level = 1'b0;
        high_program_level = 1'b0;
    end

    // One pulse, then the low gap; a high pulse also passes the mid level
    task automatic pulse(input logic [1:0] lvl, input int len);
        @(negedge core_clk);
        mid_program_level = 1'b1;
        high_program_level = (lvl == spfp_pkg::LVL_HIGH);
        repeat (len) @(negedge core_clk);
        mid_program_level = 1'b0;
        high_program_level = 1'b0;
        repeat (T_LOW) @(negedge core_clk);
    endtask

    task automatic mids(input int n);
        repeat (n) pulse(spfp_pkg::LVL_MID, T_ACT);
    endtask

    // Register selection; key zero sends no mid pulse
    task automatic select(input int key);
        pulse(spfp_pkg::LVL_HIGH, T_ACT);
        mids(key);
        pulse(spfp_pkg::LVL_HIGH, T_ACT);
    endtask

    // Blow key: nine mids then a high
    task automatic blow_key();
        mids(9);
        pulse(spfp_pkg::LVL_HIGH, T_ACT);
    endtask

    task automatic burn();
        pulse(spfp_pkg::LVL_HIGH, T_BURN);
    endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench of the fuse programmer with a fuse bank model.
// Assumes the programmer model and the design's package are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic core_clk;
    logic nrst;
    logic mid_program_level;
    logic high_program_level;
    spfp_pkg::spfp_fuse_t fuse_sense;
    spfp_pkg::spfp_fuse_t fuse_burn;
    logic [5:0] operate_threshold;
    logic check_low;
    logic check_high;
    logic blow_mode;
    logic seq_done;
    int failures = 0;
    int samples_checked = 0;

    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    // Fuse bank: a burned fuse stays burned across resets
    initial
    begin
        fuse_sense = spfp_pkg::FUSE_NONE;
        forever
        begin
            @(negedge core_clk);
            fuse_sense <= fuse_sense | fuse_burn;
        end
    end

    spfp_prog_model prog (
        .core_clk(core_clk),
        .mid_program_level(mid_program_level),
        .high_program_level(high_program_level)
    );

    spfp_programmer #(.GLITCH_CYCLES(4)) dut (
        .core_clk(core_clk),
        .nrst(nrst),
        .mid_program_level(mid_program_level),
        .high_program_level(high_program_level),
        .fuse_sense(fuse_sense),
        .fuse_burn(fuse_burn),
        .operate_threshold(operate_threshold),
        .check_low(check_low),
        .check_high(check_high),
        .blow_mode(blow_mode),
        .seq_done(seq_done)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [6:0] seen,
                         input logic [6:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Supply power cycle; four cycles flush the synchronisers
    task automatic power_cycle();
        @(negedge core_clk);
        nrst = 1'b0;
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        repeat (3) @(negedge core_clk);
    endtask

    // Full burn sequence on one key with n address pulses
    task automatic blow(input int key, input int n);
        prog.select(key);
        prog.blow_key();
        check("blow_mode", {6'h00, blow_mode}, 7'h01);
        prog.mids(n);
        prog.burn();
        check("seq_done", {6'h00, seq_done}, 7'h01);
        power_cycle();
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog: the tests need under ten thousand cycles, a quarter of the limit
    initial
    begin
        repeat (40000) @(posedge core_clk);
        failures++;
        wrap_up();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        nrst = 1'b0;
        power_cycle();
        check("reset", {operate_threshold, blow_mode}, 7'h00);
        // Up-counting trim runs past the top and must saturate
        prog.select(0);
        check("up preset", {1'b0, operate_threshold}, 7'h01);
        for (int i = 2; i <= 65; i++)
        begin
            prog.mids(1);
            check("up step", {1'b0, operate_threshold},
                  (i > 63) ? 7'h3F : 7'(i));
        end
        power_cycle();
        check("try dropped", {1'b0, operate_threshold}, 7'h00);
        $display("test up-count done");
        // Down-counting trim applies the inverse of the code
        prog.select(1);
        check("down preset", {1'b0, operate_threshold}, 7'h3E);
        prog.mids(2);
        check("down step", {1'b0, operate_threshold}, 7'h3C);
        power_cycle();
        // Fuse check codes 7 and 15
        prog.select(7);
        prog.mids(7);
        check("check low", {5'h00, check_high, check_low}, 7'h01);
        prog.mids(8);
        check("check high", {5'h00, check_high, check_low}, 7'h02);
        power_cycle();
        $display("test down-count and fuse check done");
        // Burn trim bit 2 with three address pulses
        blow(0, 3);
        check("fuses", 7'(fuse_sense), {6'h04, 1'b0});
        check("kept", {1'b0, operate_threshold}, 7'h04);
        // Mids before the first high are ignored
        prog.mids(3);
        check("idle", {5'h00, blow_mode, seq_done}, 7'h00);
        prog.select(0);
        check("fuse or try", {1'b0, operate_threshold}, 7'h05);
        power_cycle();
        // Seventh address pulse shifts the bit out, nothing burns
        blow(0, 7);
        check("no burn", 7'(fuse_sense), {6'h04, 1'b0});
        $display("test trim burn done");
        // Lock, then key 0 is refused while the fuse check stays open
        blow(7, 4);
        check("lock fuse", 7'(fuse_sense), {6'h04, 1'b1});
        prog.select(0);
        check("locked", {operate_threshold, seq_done}, {6'h04, 1'b1});
        power_cycle();
        prog.select(7);
        prog.mids(7);
        check("check after lock", {5'h00, check_high, check_low},
              7'h01);
        $display("test lock done");
        wrap_up();
    end
endmodule
`default_nettype wire
